// ==== design/smcg_pkg.sv ====
// Package: register map, field positions and types for sleep clock gating
package smcg_pkg;
    // System control base and register offsets (byte addresses)
    localparam logic [31:0] SMCG_SYSCTL_BASE = 32'h400F_E000;
    localparam logic [11:0] SMCG_RUN_CFG_OFS = 12'h060;
    localparam logic [11:0] SMCG_RUN_GATE_OFS = 12'h104;
    localparam logic [11:0] SMCG_SLEEP_GATE_OFS = 12'h114;
    localparam logic [11:0] SMCG_DEEP_GATE_OFS = 12'h124;
    localparam logic [11:0] SMCG_MODE_OFS = 12'h200;
    localparam logic [11:0] SMCG_IRQ_STAT_OFS = 12'h204;
    localparam logic [11:0] SMCG_IRQ_MASK_OFS = 12'h208;
    localparam logic [11:0] SMCG_FAULT_ADDR_OFS = 12'h20C;

    // Gate bit positions
    localparam int SMCG_BIT_ASYNC0 = 0;
    localparam int SMCG_BIT_ASYNC1 = 1;
    localparam int SMCG_BIT_SYNC = 4;
    localparam int SMCG_BIT_QUAD = 8;
    localparam int SMCG_BIT_CNT0 = 16;
    localparam int SMCG_BIT_CNT1 = 17;
    localparam int SMCG_BIT_CNT2 = 18;
    localparam int SMCG_BIT_COMP = 24;

    // Writable bits of the gating registers
    localparam logic [31:0] SMCG_GATE_WMASK = 32'h0107_0113;
    localparam logic [31:0] SMCG_GATE_RESET = 32'h0000_0000;
    // Automatic gating select bit in the run clock configuration
    localparam int SMCG_BIT_AUTO = 27;
    localparam logic [31:0] SMCG_CFG_WMASK = 32'h0800_0000;
    localparam logic [31:0] SMCG_CFG_RESET = 32'h0000_0000;

    // Interrupt status bits
    localparam int SMCG_IRQ_FAULT = 0;
    localparam int SMCG_IRQ_MODE = 1;
    localparam int SMCG_IRQ_W = 2;

    // Number of gated peripheral units
    localparam int SMCG_UNITS = 8;

    // Power modes
    typedef enum logic [2:0]
    {
        SMCG_RUN = 3'b001,
        SMCG_SLEEP = 3'b010,
        SMCG_DEEP = 3'b100
    } smcg_mode_e;

    // Peripheral access request from the system bus
    typedef struct packed
    {
        logic valid;
        logic [2:0] unit;
        logic [11:0] addr;
    } smcg_periph_req_s;

    // Register bus request
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } smcg_bus_s;
endpackage

// ==== design/smcg_gate_reg.sv ====
// One gating register with write mask and reset value
`timescale 1ns/1ps
module smcg_gate_reg
#(
    parameter logic [31:0] WMASK = 32'h0000_0000,
    parameter logic [31:0] RESET = 32'h0000_0000
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] value_o
);
    logic [31:0] value_reg;
    logic [31:0] value_next;

    // Only mapped bits take writes; reserved bits stay zero
    assign value_next = wr_i ? (wdata_i & WMASK) : value_reg;

    // Storage
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            value_reg <= RESET;
        else
            value_reg <= value_next;
    end

    assign value_o = value_reg;
endmodule

// ==== design/smcg_fault_chk.sv ====
// Bus fault check for accesses to a gated peripheral unit
`timescale 1ns/1ps
module smcg_fault_chk
    import smcg_pkg::*;
#(
    parameter int UNITS = SMCG_UNITS
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input smcg_pkg::smcg_periph_req_s req_i,
    input wire logic [UNITS-1:0] enable_i,
    output logic grant_o,
    output logic fault_o
);
    // Refuse unit counts that the 3-bit unit index cannot serve
    if (UNITS < 1 || UNITS > 8)
    begin
        $error("UNITS must lie in 1..8");
    end

    logic fault_reg;
    logic fault_next;
    logic unit_on;

    // Clocked unit passes, unclocked unit faults
    assign unit_on = (32'(req_i.unit) < UNITS) && enable_i[req_i.unit];
    assign grant_o = req_i.valid && unit_on;
    assign fault_next = req_i.valid && !unit_on;

    // Fault response one cycle after the access
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            fault_reg <= 1'b0;
        else
            fault_reg <= fault_next;
    end

    assign fault_o = fault_reg;
endmodule

// ==== design/smcg_top.sv ====
// Sleep mode clock gating controller with register port and fault check
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - Each gate bit enables one unit clock
// - Access to unclocked unit ends in fault
// - Sleep gating register resets to zero
// - Every gate bit resets to unclocked
// - Run, sleep, deep gates follow power mode with auto gating; run gate in every mode without it
// - Sleep settings used only with auto gating
// - Sleep register decodes at offset 0x114
module smcg_top
    import smcg_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic sleep_req_i,
    input wire logic deep_req_i,
    input smcg_pkg::smcg_periph_req_s periph_req_i,
    output logic periph_grant_o,
    output logic periph_fault_o,
    output logic [SMCG_UNITS-1:0] unit_clk_en_o,
    output logic [2:0] mode_o,
    output logic irq_o
);
    import smcg_pkg::*;

    // Register port bundle and block decode
    smcg_bus_s bus;
    logic in_block;
    logic [11:0] ofs;

    // Per-register selects
    logic sel_cfg;
    logic sel_run;
    logic sel_sleep;
    logic sel_deep;
    logic sel_mode;
    logic sel_stat;
    logic sel_mask;
    logic sel_faddr;

    // Per-register write strobes
    logic wr_cfg;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_stat;
    logic wr_mask;

    // Register contents and read path
    logic [31:0] cfg_val;
    logic [31:0] run_val;
    logic [31:0] sleep_val;
    logic [31:0] deep_val;
    logic [31:0] mode_word;
    logic [31:0] stat_word;
    logic [31:0] mask_word;
    logic [31:0] faddr_word;
    logic [31:0] rd_mux;
    logic [31:0] rdata_reg;

    // Gate set in force and per-unit enables
    logic [31:0] active_gate;
    logic en_async0;
    logic en_async1;
    logic en_sync;
    logic en_quad;
    logic en_cnt0;
    logic en_cnt1;
    logic en_cnt2;
    logic en_comp;
    logic [SMCG_UNITS-1:0] clk_en_reg;
    logic [SMCG_UNITS-1:0] clk_en_next;

    // Power mode
    smcg_mode_e mode_reg;
    smcg_mode_e mode_next;
    logic mode_chg;

    // Interrupt status, mask and fault capture
    logic [SMCG_IRQ_W-1:0] stat_reg;
    logic [SMCG_IRQ_W-1:0] stat_next;
    logic [SMCG_IRQ_W-1:0] mask_reg;
    logic [SMCG_IRQ_W-1:0] mask_next;
    logic [SMCG_IRQ_W-1:0] stat_set;
    logic [SMCG_IRQ_W-1:0] stat_clr;
    logic [11:0] faddr_reg;
    logic [11:0] faddr_next;
    logic fault;
    logic fault_cap;
    logic auto_on;

    // Mapped gate bits, built from the bit positions
    localparam logic [31:0] UNIT_MAP = (32'h0000_0001 << SMCG_BIT_ASYNC0)
        | (32'h0000_0001 << SMCG_BIT_ASYNC1)
        | (32'h0000_0001 << SMCG_BIT_SYNC)
        | (32'h0000_0001 << SMCG_BIT_QUAD)
        | (32'h0000_0001 << SMCG_BIT_CNT0)
        | (32'h0000_0001 << SMCG_BIT_CNT1)
        | (32'h0000_0001 << SMCG_BIT_CNT2)
        | (32'h0000_0001 << SMCG_BIT_COMP);

    // Elaboration checks: eight units, map equals writable bits
    if (SMCG_UNITS != 8)
    begin
        $error("smcg_top serves exactly eight units");
    end
    if (UNIT_MAP != SMCG_GATE_WMASK)
    begin
        $error("gate bit map differs from the write mask");
    end

    // Bundle the register port
    assign bus.wr = wr_i;
    assign bus.rd = rd_i;
    assign bus.addr = addr_i;
    assign bus.wdata = wdata_i;

    // Address decode within the system control block
    assign in_block = (bus.addr[31:12] == SMCG_SYSCTL_BASE[31:12]);
    assign ofs = bus.addr[11:0];
    assign sel_cfg = in_block && (ofs == SMCG_RUN_CFG_OFS);
    assign sel_run = in_block && (ofs == SMCG_RUN_GATE_OFS);
    assign sel_sleep = in_block && (ofs == SMCG_SLEEP_GATE_OFS);
    assign sel_deep = in_block && (ofs == SMCG_DEEP_GATE_OFS);
    assign sel_mode = in_block && (ofs == SMCG_MODE_OFS);
    assign sel_stat = in_block && (ofs == SMCG_IRQ_STAT_OFS);
    assign sel_mask = in_block && (ofs == SMCG_IRQ_MASK_OFS);
    assign sel_faddr = in_block && (ofs == SMCG_FAULT_ADDR_OFS);

    // Write strobes per register
    assign wr_cfg = bus.wr && sel_cfg;
    assign wr_run = bus.wr && sel_run;
    assign wr_sleep = bus.wr && sel_sleep;
    assign wr_deep = bus.wr && sel_deep;
    assign wr_stat = bus.wr && sel_stat;
    assign wr_mask = bus.wr && sel_mask;

    // Run clock configuration holding the auto gating select
    smcg_gate_reg #(.WMASK(SMCG_CFG_WMASK), .RESET(SMCG_CFG_RESET)) u_cfg
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_cfg),
        .wdata_i(bus.wdata),
        .value_o(cfg_val)
    );

    // Run mode gating register
    smcg_gate_reg #(.WMASK(SMCG_GATE_WMASK), .RESET(SMCG_GATE_RESET)) u_run
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_run),
        .wdata_i(bus.wdata),
        .value_o(run_val)
    );

    // Sleep mode gating register, all zero after reset
    smcg_gate_reg #(.WMASK(SMCG_GATE_WMASK), .RESET(SMCG_GATE_RESET)) u_slp
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_sleep),
        .wdata_i(bus.wdata),
        .value_o(sleep_val)
    );

    // Deep sleep gating register
    smcg_gate_reg #(.WMASK(SMCG_GATE_WMASK), .RESET(SMCG_GATE_RESET)) u_dsl
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_deep),
        .wdata_i(bus.wdata),
        .value_o(deep_val)
    );

    // Power mode follows the requests; deep sleep has priority
    always_comb
    begin
        if (deep_req_i)
            mode_next = SMCG_DEEP;
        else if (sleep_req_i)
            mode_next = SMCG_SLEEP;
        else
            mode_next = SMCG_RUN;
    end

    // Mode register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            mode_reg <= SMCG_RUN;
        else
            mode_reg <= mode_next;
    end

    // Automatic gating select from the run configuration
    assign auto_on = cfg_val[SMCG_BIT_AUTO];

    // Gate set in force for the current mode
    always_comb
    begin
        case (mode_reg)
            SMCG_SLEEP: active_gate = auto_on ? sleep_val : run_val;
            SMCG_DEEP: active_gate = auto_on ? deep_val : run_val;
            default: active_gate = run_val;
        endcase
    end

    // Pick each unit's gate bit out of the set in force
    assign en_async0 = active_gate[SMCG_BIT_ASYNC0];
    assign en_async1 = active_gate[SMCG_BIT_ASYNC1];
    assign en_sync = active_gate[SMCG_BIT_SYNC];
    assign en_quad = active_gate[SMCG_BIT_QUAD];
    assign en_cnt0 = active_gate[SMCG_BIT_CNT0];
    assign en_cnt1 = active_gate[SMCG_BIT_CNT1];
    assign en_cnt2 = active_gate[SMCG_BIT_CNT2];
    assign en_comp = active_gate[SMCG_BIT_COMP];

    // Gather mapped bits into one enable per unit
    assign clk_en_next = {
        en_comp,
        en_cnt2,
        en_cnt1,
        en_cnt0,
        en_quad,
        en_sync,
        en_async1,
        en_async0
    };

    // Registered clock enables, all units off after reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            clk_en_reg <= '0;
        else
            clk_en_reg <= clk_en_next;
    end

    // Fault check against the enables in force
    smcg_fault_chk #(.UNITS(SMCG_UNITS)) u_chk
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .req_i(periph_req_i),
        .enable_i(clk_en_reg),
        .grant_o(periph_grant_o),
        .fault_o(fault)
    );

    // Events: access refused, power mode moving
    assign fault_cap = periph_req_i.valid && !periph_grant_o;
    assign mode_chg = (mode_next != mode_reg);

    // Capture the address of a faulting access
    assign faddr_next = fault_cap
        ? periph_req_i.addr : faddr_reg;

    // Sticky events: fault and mode change; set wins over clear
    assign stat_set = {mode_chg, fault};
    assign stat_clr = wr_stat
        ? bus.wdata[SMCG_IRQ_W-1:0] : '0;
    assign stat_next = (stat_reg & ~stat_clr) | stat_set;
    assign mask_next = wr_mask
        ? bus.wdata[SMCG_IRQ_W-1:0] : mask_reg;

    // Sticky status register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            stat_reg <= '0;
        else
            stat_reg <= stat_next;
    end

    // Interrupt mask register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            mask_reg <= '0;
        else
            mask_reg <= mask_next;
    end

    // Address of the last refused access
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            faddr_reg <= '0;
        else
            faddr_reg <= faddr_next;
    end

    // Zero-extended read words for the narrow registers
    assign mode_word = 32'(mode_reg);
    assign stat_word = 32'(stat_reg);
    assign mask_word = 32'(mask_reg);
    assign faddr_word = 32'(faddr_reg);

    // Read selection; reserved bits and unmapped offsets read zero
    always_comb
    begin
        if (sel_cfg)
            rd_mux = cfg_val;
        else if (sel_run)
            rd_mux = run_val;
        else if (sel_sleep)
            rd_mux = sleep_val;
        else if (sel_deep)
            rd_mux = deep_val;
        else if (sel_mode)
            rd_mux = mode_word;
        else if (sel_stat)
            rd_mux = stat_word;
        else if (sel_mask)
            rd_mux = mask_word;
        else if (sel_faddr)
            rd_mux = faddr_word;
        else
            rd_mux = 32'h0000_0000;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= bus.rd ? rd_mux : 32'h0000_0000;
    end

    // Outputs from registers
    assign rdata_o = rdata_reg;
    assign unit_clk_en_o = clk_en_reg;
    assign periph_fault_o = fault;
    assign mode_o = mode_reg;

    // Level interrupt from unmasked sticky bits
    assign irq_o = |(stat_reg & mask_reg);
endmodule

// ==== testbench/smcg_top_asserts.sv ====
// Port assertions for the sleep clock gating controller
`timescale 1ns/1ps
module smcg_top_asserts
    import smcg_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic sleep_req_i,
    input wire logic deep_req_i,
    input smcg_pkg::smcg_periph_req_s periph_req_i,
    input wire logic periph_grant_o,
    input wire logic periph_fault_o,
    input wire logic [SMCG_UNITS-1:0] unit_clk_en_o,
    input wire logic [2:0] mode_o
);
    // One clock domain, reset cancels every check
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Read data only in the slot after a read
    property p_rdata_idle;
        !$past(rd_i) |-> rdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");

    // Grant follows the unit clock enable
    property p_grant;
        periph_req_i.valid |-> periph_grant_o ==
            unit_clk_en_o[periph_req_i.unit];
    endproperty
    a_grant: assert property (p_grant)
        else $error("grant does not match unit enable");

    // Access to an unclocked unit faults next cycle
    property p_fault;
        periph_req_i.valid && !periph_grant_o |=> periph_fault_o;
    endproperty
    a_fault: assert property (p_fault)
        else $error("missing fault");

    // Fault only after a refused access
    property p_fault_cause;
        periph_fault_o |-> $past(periph_req_i.valid) &&
            !$past(periph_grant_o);
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault without refused access");

    // Everything unclocked, run mode right after reset
    property p_reset;
        $fell(sys_rst_i) |-> unit_clk_en_o == '0 && mode_o == 3'b001;
    endproperty
    a_reset: assert property (p_reset)
        else $error("bad state after reset");

    // Mode is always one-hot
    property p_onehot;
        $onehot(mode_o);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("mode not one-hot");

    // Deep request wins over sleep
    property p_deep;
        deep_req_i |=> mode_o == 3'b100;
    endproperty
    a_deep: assert property (p_deep)
        else $error("deep request not followed");

    // Sleep request alone gives sleep mode
    property p_sleep;
        sleep_req_i && !deep_req_i |=> mode_o == 3'b010;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep request not followed");

    // Enables move only after a write or a mode change
    property p_en_cause;
        $changed(unit_clk_en_o) |-> $past(wr_i, 2) ||
            $past(mode_o) != $past(mode_o, 2);
    endproperty
    a_en_cause: assert property (p_en_cause)
        else $error("enable changed without cause");

    // Main scenarios
    c_fault: cover property (periph_fault_o);
    c_deep: cover property (mode_o == 3'b100);
    c_read: cover property (rd_i ##1 rdata_o != 32'h0000_0000);
endmodule

bind smcg_top smcg_top_asserts i_smcg_top_asserts
(
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .sleep_req_i(sleep_req_i),
    .deep_req_i(deep_req_i),
    .periph_req_i(periph_req_i),
    .periph_grant_o(periph_grant_o),
    .periph_fault_o(periph_fault_o),
    .unit_clk_en_o(unit_clk_en_o),
    .mode_o(mode_o)
);

// ==== testbench/tb.sv ====
// Directed testbench for the sleep clock gating controller
`timescale 1ns/1ps
module tb;
    import smcg_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [31:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_req_i = 1'b0;
    logic deep_req_i = 1'b0;
    smcg_periph_req_s periph_req_i = '0;
    logic [31:0] rdata_o;
    logic periph_grant_o;
    logic periph_fault_o;
    logic [SMCG_UNITS-1:0] unit_clk_en_o;
    logic [2:0] mode_o;
    logic irq_o;
    int errors = 0;
    int samples_checked = 0;
    int pos [8] = '{SMCG_BIT_ASYNC0, SMCG_BIT_ASYNC1, SMCG_BIT_SYNC,
        SMCG_BIT_QUAD, SMCG_BIT_CNT0, SMCG_BIT_CNT1, SMCG_BIT_CNT2,
        SMCG_BIT_COMP};

    // Device under test
    smcg_top i_smcg_top
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .sleep_req_i(sleep_req_i),
        .deep_req_i(deep_req_i),
        .periph_req_i(periph_req_i),
        .periph_grant_o(periph_grant_o),
        .periph_fault_o(periph_fault_o),
        .unit_clk_en_o(unit_clk_en_o),
        .mode_o(mode_o),
        .irq_o(irq_o)
    );

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One-cycle register write
    task automatic reg_wr(input logic [11:0] ofs, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= SMCG_SYSCTL_BASE + 32'(ofs);
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read, data taken in the following slot
    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= SMCG_SYSCTL_BASE + 32'(ofs);
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask

    // Let enables follow a register or mode change
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Peripheral access, grant now, fault one cycle later
    task automatic acc(input logic [2:0] u, input logic g);
        @(posedge clk_i);
        periph_req_i <= '{valid: 1'b1, unit: u, addr: 12'h010};
        #1;
        chk({31'h0, periph_grant_o}, {31'h0, g});
        @(posedge clk_i);
        periph_req_i <= '0;
        #1;
        chk({31'h0, periph_fault_o}, {31'h0, !g});
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(SMCG_SLEEP_GATE_OFS, 32'h0000_0000);
        chk(32'(unit_clk_en_o), 32'h0000_0000);
        reg_wr(SMCG_SLEEP_GATE_OFS, 32'h0107_0113);
        rd_chk(SMCG_SLEEP_GATE_OFS, 32'h0107_0113);
        reg_wr(SMCG_RUN_GATE_OFS, 32'h0000_0001);
        sleep_req_i <= 1'b1;
        settle();
        chk(32'(unit_clk_en_o), 32'h0000_0001);
        reg_wr(SMCG_RUN_CFG_OFS, 32'h0800_0000);
        settle();
        chk(32'(unit_clk_en_o), 32'h0000_00FF);
        for (int i = 0; i < 8; i++)
        begin
            reg_wr(SMCG_SLEEP_GATE_OFS, 32'h0000_0001 << pos[i]);
            settle();
            chk(32'(unit_clk_en_o), 32'h0000_0001 << i);
        end
        reg_wr(SMCG_DEEP_GATE_OFS, 32'h0000_0100);
        deep_req_i <= 1'b1;
        settle();
        chk(32'(unit_clk_en_o), 32'h0000_0008);
        rd_chk(SMCG_MODE_OFS, 32'h0000_0004);
        chk(32'(mode_o), 32'h0000_0004);
        deep_req_i <= 1'b0;
        sleep_req_i <= 1'b0;
        settle();
        chk(32'(unit_clk_en_o), 32'h0000_0001);
        acc(3'd0, 1'b1);
        acc(3'd1, 1'b0);
        rd_chk(SMCG_FAULT_ADDR_OFS, 32'h0000_0010);
        reg_wr(SMCG_IRQ_MASK_OFS, 32'h0000_0003);
        settle();
        chk(32'(irq_o), 32'h0000_0001);
        rd_chk(SMCG_IRQ_STAT_OFS, 32'h0000_0003);
        reg_wr(SMCG_IRQ_STAT_OFS, 32'h0000_0003);
        settle();
        chk(32'(irq_o), 32'h0000_0000);
        rd_chk(SMCG_IRQ_STAT_OFS, 32'h0000_0000);
        sleep_req_i <= 1'b1;
        settle();
        chk(32'(irq_o), 32'h0000_0001);
        sleep_req_i <= 1'b0;
        settle();
        reg_wr(12'h300, 32'hFFFF_FFFF);
        rd_chk(12'h300, 32'h0000_0000);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(SMCG_SLEEP_GATE_OFS, 32'h0000_0000);
        rd_chk(SMCG_RUN_CFG_OFS, 32'h0000_0000);
        chk(32'(unit_clk_en_o), 32'h0000_0000);
        chk(32'(mode_o), 32'h0000_0001);
        end_of_test();
    end
endmodule
